// >>> hw/hlar_top.sv
`timescale 1ns/10ps
`default_nettype none
module hlar_top #(
  parameter int POWERUP_CYCLES = hlar_pkg::HLAR_POWERUP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hw_reset_n_pin,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic host_alert_n_in,
  output logic host_alert_n_out,
  output logic host_alert_n_oe,
  input wire logic key_event,
  input wire logic mode_entered,
  input wire logic comp_done,
  input wire logic shadow_write_done,
  input wire logic burn_done,
  input wire logic scan_tick,
  input wire logic core_scanning,
  input wire logic params_reload_done,
  input wire logic nvm_valid,
  input wire logic [6:0] nvm_slave_addr,
  output logic params_reload_req,
  output logic params_src_nvm,
  output logic gpio_use_shadow,
  output logic core_reset_n,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data,
  output logic reg_wr_stb,
  output logic reg_rd_stb,
  input wire logic [7:0] reg_rd_data
);
  import hlar_pkg::*;

  hlar_ctl_if ctl_if ();

  hlar_alert #(
    .POWERUP_CYCLES(POWERUP_CYCLES)
  ) u_alert (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .hw_reset_n_pin(hw_reset_n_pin),
    .key_event(key_event),
    .mode_entered(mode_entered),
    .comp_done(comp_done),
    .shadow_write_done(shadow_write_done),
    .burn_done(burn_done),
    .scan_tick(scan_tick),
    .core_scanning(core_scanning),
    .params_reload_done(params_reload_done),
    .nvm_valid(nvm_valid),
    .ctl(ctl_if.ctl),
    .host_alert_n_oe(host_alert_n_oe),
    .params_reload_req(params_reload_req),
    .params_src_nvm(params_src_nvm),
    .gpio_use_shadow(gpio_use_shadow),
    .core_reset_n(core_reset_n)
  );

  // ****************************************
  // bus line synchronisers and edge detect
  // ****************************************
  // oversampling at the system clock covers both bus rates alike
  logic [2:0] scl_sync_reg, scl_sync_next;
  logic [2:0] sda_sync_reg, sda_sync_next;
  logic scl_f_reg, scl_f_next, sda_f_reg, sda_f_next;
  logic scl_prev_reg, sda_prev_reg;
  logic od_low_reg;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_comb begin
    scl_sync_next = {scl_sync_reg[1:0], scl_in};
    sda_sync_next = {sda_sync_reg[1:0], sda_in};
    scl_f_next = hlar_sync_filt(scl_sync_reg[1], scl_sync_reg[2], scl_f_reg);
    sda_f_next = hlar_sync_filt(sda_sync_reg[1], sda_sync_reg[2], sda_f_reg);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      scl_sync_reg <= HLAR_SYNC_IDLE;
      sda_sync_reg <= HLAR_SYNC_IDLE;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      od_low_reg <= 1'b0;
    end else begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
      scl_prev_reg <= scl_f_reg;
      sda_prev_reg <= sda_f_reg;
      od_low_reg <= 1'b0;
    end
  end

  assign scl_rise = scl_f_reg & ~scl_prev_reg;
  assign scl_fall = ~scl_f_reg & scl_prev_reg;
  assign bus_start = scl_f_reg & scl_prev_reg & sda_prev_reg & ~sda_f_reg;
  assign bus_stop = scl_f_reg & scl_prev_reg & ~sda_prev_reg & sda_f_reg;

  // ****************************************
  // serial slave and soft reset decode
  // ****************************************
  hlar_i2c_st_e st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] addr_reg, addr_next;
  logic [7:0] wdat_reg, wdat_next;
  logic [6:0] sa_reg, sa_next;
  logic first_reg, first_next;
  logic rw_reg, rw_next;
  logic oe_reg, oe_next;
  logic cont_reg, cont_next;
  logic armed_reg, armed_next;
  logic wr_reg, wr_next;
  logic rd_reg, rd_next;
  logic srst_reg, srst_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    addr_next = addr_reg;
    wdat_next = wdat_reg;
    sa_next = sa_reg;
    first_next = first_reg;
    rw_next = rw_reg;
    oe_next = oe_reg;
    cont_next = cont_reg;
    armed_next = armed_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    srst_next = 1'b0;
    if (ctl_if.addr_load) begin
      sa_next = nvm_valid ? nvm_slave_addr : HLAR_DEF_SLAVE_ADDR;
    end
    // the slave stays deaf until the power-up sequence lets go of the alert
    if (!ctl_if.ready) begin
      st_next = HLAR_I_IDLE;
      oe_next = 1'b0;
      armed_next = 1'b0;
    end else if (bus_start) begin
      st_next = HLAR_I_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (bus_stop) begin
      st_next = HLAR_I_IDLE;
      oe_next = 1'b0;
    end else begin
      case (st_reg)
        HLAR_I_ADDR: begin
          if (scl_rise && cnt_reg != HLAR_BYTE_BITS) begin
            sh_next = {sh_reg[6:0], sda_f_reg};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == HLAR_BYTE_BITS) begin
            if (sh_reg[7:1] == sa_reg) begin
              oe_next = 1'b1;
              rw_next = sh_reg[0];
              st_next = HLAR_I_ADDR_ACK;
            end else begin
              st_next = HLAR_I_IDLE;
            end
          end
        end
        HLAR_I_ADDR_ACK: begin
          if (scl_rise && rw_reg) begin
            rd_next = 1'b1;
            addr_next = ptr_reg;
            ptr_next = ptr_reg + 8'h01;
          end else if (scl_fall) begin
            cnt_next = 4'h0;
            if (rw_reg) begin
              sh_next = reg_rd_data;
              oe_next = ~reg_rd_data[7];
              st_next = HLAR_I_READ;
            end else begin
              oe_next = 1'b0;
              first_next = 1'b1;
              st_next = HLAR_I_WRITE;
            end
          end
        end
        HLAR_I_WRITE: begin
          if (scl_rise && cnt_reg != HLAR_BYTE_BITS) begin
            sh_next = {sh_reg[6:0], sda_f_reg};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == HLAR_BYTE_BITS) begin
            oe_next = 1'b1;
            st_next = HLAR_I_WRITE_ACK;
            if (first_reg) begin
              ptr_next = sh_reg;
              first_next = 1'b0;
            end else begin
              ptr_next = ptr_reg + 8'h01;
              if (ptr_reg == HLAR_SOFT_RESET_OFFS) begin
                if (sh_reg == HLAR_SRST_KEY_ARM) begin
                  armed_next = 1'b1;
                end else if (sh_reg == HLAR_SRST_KEY_FIRE && armed_reg) begin
                  srst_next = 1'b1;
                  armed_next = 1'b0;
                end else begin
                  armed_next = 1'b0;
                end
              end else begin
                addr_next = ptr_reg;
                wdat_next = sh_reg;
                wr_next = 1'b1;
              end
            end
          end
        end
        HLAR_I_WRITE_ACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            cnt_next = 4'h0;
            st_next = HLAR_I_WRITE;
          end
        end
        HLAR_I_READ: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == HLAR_BYTE_BITS) begin
              oe_next = 1'b0;
              cont_next = 1'b0;
              st_next = HLAR_I_READ_ACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = ~sh_reg[6];
            end
          end
        end
        HLAR_I_READ_ACK: begin
          if (scl_rise) begin
            if (!sda_f_reg) begin
              rd_next = 1'b1;
              addr_next = ptr_reg;
              ptr_next = ptr_reg + 8'h01;
              cont_next = 1'b1;
            end else begin
              st_next = HLAR_I_IDLE;
            end
          end else if (scl_fall && cont_reg) begin
            sh_next = reg_rd_data;
            oe_next = ~reg_rd_data[7];
            cnt_next = 4'h0;
            st_next = HLAR_I_READ;
          end
        end
        default: st_next = HLAR_I_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_reg <= HLAR_I_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      addr_reg <= 8'h00;
      wdat_reg <= 8'h00;
      sa_reg <= HLAR_DEF_SLAVE_ADDR;
      first_reg <= 1'b0;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      cont_reg <= 1'b0;
      armed_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      srst_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      addr_reg <= addr_next;
      wdat_reg <= wdat_next;
      sa_reg <= sa_next;
      first_reg <= first_next;
      rw_reg <= rw_next;
      oe_reg <= oe_next;
      cont_reg <= cont_next;
      armed_reg <= armed_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      srst_reg <= srst_next;
    end
  end

  assign ctl_if.sw_reset = srst_reg;
  assign ctl_if.host_read = rd_reg;
  assign sda_out = od_low_reg;
  assign sda_oe = oe_reg;
  assign host_alert_n_out = od_low_reg;
  assign reg_addr = addr_reg;
  assign reg_wr_data = wdat_reg;
  assign reg_wr_stb = wr_reg;
  assign reg_rd_stb = rd_reg;
endmodule // hlar_top
`default_nettype wire

// >>> hw/hlar_pkg.sv
`default_nettype none
package hlar_pkg;
  // ****************************************
  // clocking and timing
  // ****************************************
  localparam int HLAR_CLK_SYS_KHZ = 25000;
  // oscillator core rate; the system clock above is its only derived domain
  localparam int HLAR_CORE_OSC_KHZ = 16700;
  localparam int HLAR_STD_RATE_KBPS = 100;
  localparam int HLAR_FAST_RATE_KBPS = 400;
  localparam int HLAR_POWERUP_TIME_US = 100;
  // least time, rounded up to whole cycles
  localparam int HLAR_POWERUP_CYCLES = (HLAR_POWERUP_TIME_US * HLAR_CLK_SYS_KHZ + 999) / 1000;

  // ****************************************
  // addresses, keys and field sizes
  // ****************************************
  localparam logic [6:0] HLAR_DEF_SLAVE_ADDR = 7'h2B;
  localparam logic [7:0] HLAR_SOFT_RESET_OFFS = 8'hB1;
  localparam logic [7:0] HLAR_SRST_KEY_ARM = 8'hDE;
  localparam logic [7:0] HLAR_SRST_KEY_FIRE = 8'h00;
  localparam logic [3:0] HLAR_BYTE_BITS = 4'h8;
  localparam logic [2:0] HLAR_SYNC_IDLE = 3'h7;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [2:0] {
    HLAR_I_IDLE = 3'b000,
    HLAR_I_ADDR = 3'b001,
    HLAR_I_ADDR_ACK = 3'b010,
    HLAR_I_WRITE = 3'b011,
    HLAR_I_WRITE_ACK = 3'b100,
    HLAR_I_READ = 3'b101,
    HLAR_I_READ_ACK = 3'b110
  } hlar_i2c_st_e;

  typedef enum logic [1:0] {
    HLAR_R_HOLD = 2'b00,
    HLAR_R_INIT = 2'b01,
    HLAR_R_RELOAD = 2'b10,
    HLAR_R_RUN = 2'b11
  } hlar_rst_st_e;

  // a pin level only counts once the second and third stage agree
  function automatic logic hlar_sync_filt(input logic s2, input logic s3, input logic f);
    hlar_sync_filt = (s2 == s3) ? s3 : f;
  endfunction
endpackage
`default_nettype wire

// >>> hw/hlar_ctl_if.sv
`timescale 1ns/10ps
`default_nettype none
interface hlar_ctl_if;
  logic sw_reset;
  logic host_read;
  logic ready;
  logic addr_load;
  modport slave (output sw_reset, output host_read, input ready, input addr_load);
  modport ctl (input sw_reset, input host_read, output ready, output addr_load);
endinterface
`default_nettype wire

// >>> hw/hlar_alert.sv
`timescale 1ns/10ps
`default_nettype none
module hlar_alert #(
  parameter int POWERUP_CYCLES = hlar_pkg::HLAR_POWERUP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hw_reset_n_pin,
  input wire logic key_event,
  input wire logic mode_entered,
  input wire logic comp_done,
  input wire logic shadow_write_done,
  input wire logic burn_done,
  input wire logic scan_tick,
  input wire logic core_scanning,
  input wire logic params_reload_done,
  input wire logic nvm_valid,
  hlar_ctl_if.ctl ctl,
  output logic host_alert_n_oe,
  output logic params_reload_req,
  output logic params_src_nvm,
  output logic gpio_use_shadow,
  output logic core_reset_n
);
  import hlar_pkg::*;

  localparam int CNT_W = $clog2(POWERUP_CYCLES + 1);

  // ****************************************
  // reset pin synchroniser
  // ****************************************
  logic [2:0] pin_sync_reg;
  logic pin_f_reg;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_sync_reg <= 3'h0;
      pin_f_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], hw_reset_n_pin};
      pin_f_reg <= hlar_sync_filt(pin_sync_reg[1], pin_sync_reg[2], pin_f_reg);
    end
  end

  // ****************************************
  // reset sequencer and alert line
  // ****************************************
  hlar_rst_st_e st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic alert_reg, alert_next;
  logic pend_reg, pend_next;
  logic req_reg, req_next;
  logic src_reg, src_next;
  logic gpio_reg, gpio_next;
  logic core_reg, core_next;
  logic ready_reg, ready_next;
  logic load_reg, load_next;
  logic evt;

  assign evt = key_event | mode_entered | comp_done | shadow_write_done | burn_done;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    alert_next = alert_reg;
    pend_next = pend_reg;
    req_next = 1'b0;
    src_next = src_reg;
    gpio_next = gpio_reg;
    core_next = 1'b1;
    ready_next = ready_reg;
    load_next = 1'b0;
    // only the pin and the two-byte command can restart; power-up is reset_n
    if (!pin_f_reg || ctl.sw_reset) begin
      st_next = HLAR_R_HOLD;
      alert_next = 1'b1;
      pend_next = 1'b0;
      gpio_next = 1'b0;
      ready_next = 1'b0;
      core_next = 1'b0;
    end else begin
      case (st_reg)
        HLAR_R_HOLD: begin
          cnt_next = '0;
          st_next = HLAR_R_INIT;
        end
        HLAR_R_INIT: begin
          alert_next = 1'b1;
          if (cnt_reg == CNT_W'(POWERUP_CYCLES - 1)) begin
            st_next = HLAR_R_RELOAD;
            req_next = 1'b1;
            src_next = nvm_valid;
          end else begin
            cnt_next = cnt_reg + CNT_W'(1);
          end
        end
        HLAR_R_RELOAD: begin
          if (params_reload_done) begin
            st_next = HLAR_R_RUN;
            alert_next = 1'b0;
            gpio_next = 1'b1;
            ready_next = 1'b1;
            load_next = 1'b1;
          end
        end
        HLAR_R_RUN: begin
          if (ctl.host_read) begin
            alert_next = 1'b0;
          end
          // events wait for the scan boundary while the core is scanning; asserting wins over a read
          if (scan_tick || !core_scanning) begin
            if (pend_reg) begin
              alert_next = 1'b1;
            end
            pend_next = 1'b0;
          end
          if (evt) begin
            pend_next = 1'b1;
          end
        end
        default: st_next = HLAR_R_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_reg <= HLAR_R_HOLD;
      cnt_reg <= '0;
      alert_reg <= 1'b1;
      pend_reg <= 1'b0;
      req_reg <= 1'b0;
      src_reg <= 1'b0;
      gpio_reg <= 1'b0;
      core_reg <= 1'b0;
      ready_reg <= 1'b0;
      load_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      alert_reg <= alert_next;
      pend_reg <= pend_next;
      req_reg <= req_next;
      src_reg <= src_next;
      gpio_reg <= gpio_next;
      core_reg <= core_next;
      ready_reg <= ready_next;
      load_reg <= load_next;
    end
  end

  assign host_alert_n_oe = alert_reg;
  assign params_reload_req = req_reg;
  assign params_src_nvm = src_reg;
  assign gpio_use_shadow = gpio_reg;
  assign core_reset_n = core_reg;
  assign ctl.ready = ready_reg;
  assign ctl.addr_load = load_reg;
endmodule // hlar_alert
`default_nettype wire

// >>> dv/hlar_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module hlar_top_assertions #(
  parameter int POWERUP_CYCLES = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hw_reset_n_pin,
  input wire logic sda_oe,
  input wire logic host_alert_n_oe,
  input wire logic key_event,
  input wire logic mode_entered,
  input wire logic comp_done,
  input wire logic shadow_write_done,
  input wire logic burn_done,
  input wire logic scan_tick,
  input wire logic core_scanning,
  input wire logic params_reload_done,
  input wire logic nvm_valid,
  input wire logic params_src_nvm,
  input wire logic gpio_use_shadow,
  input wire logic core_reset_n,
  input wire logic reg_rd_stb
);
  // ****************************************
  // alert and reset checks
  // ****************************************
  logic [15:0] init_cnt_reg;
  logic [15:0] init_cnt_next;
  logic other_ev;
  assign other_ev = mode_entered | comp_done | shadow_write_done | burn_done;
  // cycles spent before release; saturates so a stuck reset cannot wrap
  always_comb begin
    init_cnt_next = init_cnt_reg;
    if (!reset_n || gpio_use_shadow) begin
      init_cnt_next = 16'h0000;
    end else if (init_cnt_reg != 16'hFFFF) begin
      init_cnt_next = init_cnt_reg + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys) begin
    init_cnt_reg <= init_cnt_next;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_reset_holds_alert: assert property ($rose(reset_n) |-> host_alert_n_oe)
    else $error("alert not held at reset release");
  a_powerup_length: assert property ($rose(gpio_use_shadow) |-> {16'h0000, init_cnt_reg} >= POWERUP_CYCLES)
    else $error("released before power-up time");
  a_release_after_load: assert property ($rose(gpio_use_shadow) |-> $fell(host_alert_n_oe) && $past(params_reload_done))
    else $error("release not tied to parameter load");
  a_source_select: assert property ($rose(gpio_use_shadow) |-> params_src_nvm == nvm_valid)
    else $error("wrong parameter source");
  a_quiet_in_reset: assert property (!gpio_use_shadow && !$past(gpio_use_shadow, 3) |-> !sda_oe)
    else $error("bus answered during reset");
  a_tick_paced: assert property ($rose(host_alert_n_oe) && gpio_use_shadow && $past(core_scanning) |-> $past(scan_tick))
    else $error("alert raised between scan ticks");
  a_tick_promotes: assert property (scan_tick && !$past(scan_tick) && $past(key_event | other_ev)
    && $past(gpio_use_shadow) && gpio_use_shadow |=> host_alert_n_oe)
    else $error("pending event not promoted on tick");
  a_event_alerts: assert property (key_event && !core_scanning && gpio_use_shadow |-> ##[1:3] host_alert_n_oe)
    else $error("button event gave no alert");
  a_read_clears: assert property (reg_rd_stb && host_alert_n_oe && core_scanning && !scan_tick |=> !host_alert_n_oe)
    else $error("read did not clear alert");
  a_alert_sticky: assert property (host_alert_n_oe && gpio_use_shadow && !reg_rd_stb |=> host_alert_n_oe)
    else $error("alert dropped without a read");
  a_pin_resets: assert property ($fell(hw_reset_n_pin) ##1 !hw_reset_n_pin [*6] |-> host_alert_n_oe && !core_reset_n)
    else $error("pin low did not reset");
  c_alert_raise: cover property ($rose(host_alert_n_oe) && gpio_use_shadow);
  c_read_clear: cover property (reg_rd_stb && host_alert_n_oe);
  c_soft_reset: cover property ($fell(core_reset_n) && hw_reset_n_pin);
endmodule // hlar_top_assertions
bind hlar_top hlar_top_assertions #(.POWERUP_CYCLES(POWERUP_CYCLES)) i_chk (
  .clk_sys, .reset_n, .hw_reset_n_pin, .sda_oe, .host_alert_n_oe, .key_event, .mode_entered, .comp_done,
  .shadow_write_done, .burn_done, .scan_tick, .core_scanning, .params_reload_done, .nvm_valid,
  .params_src_nvm, .gpio_use_shadow, .core_reset_n, .reg_rd_stb
);
`default_nettype wire

// >>> dv/hlar_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hlar_host_model (
  input wire logic clk_sys,
  input wire logic sda_wire,
  input wire logic alert_wire,
  output logic scl,
  output logic sda_drive
);
  // ****************************************
  // host side of the serial bus
  // ****************************************
  // quarter bit in clocks: 16 is about 390 kb/s, 62 about 100 kb/s
  int q = 16;
  initial begin
    scl = 1'b1;
    sda_drive = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // lines change just after an edge and hold a quarter bit
  task automatic lines(input logic c, input logic d);
    scl = c;
    sda_drive = d;
    tick(q);
  endtask
  task automatic bit_io(input logic b, output logic r);
    lines(1'b0, !b);
    lines(1'b1, !b);
    r = sda_wire;
    lines(1'b1, !b);
    lines(1'b0, !b);
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic nack, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(nack, r);
    ack = !r;
  endtask
  task automatic start();
    lines(scl, 1'b0);
    lines(1'b1, 1'b0);
    lines(1'b1, 1'b1);
    lines(1'b0, 1'b1);
  endtask
  task automatic stop();
    lines(1'b0, 1'b1);
    lines(1'b1, 1'b1);
    lines(1'b1, 1'b0);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic k1, k2, k3;
    start();
    byte_io({a, 1'b0}, 1'b1, x, k1);
    byte_io(p, 1'b1, x, k2);
    byte_io(d, 1'b1, x, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // pointer write, repeated start, two bytes read, the last closed with a nack
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic [7:0] d2,
    output logic ok);
    logic [7:0] x;
    logic k1, k2, k3, k4;
    start();
    byte_io({a, 1'b0}, 1'b1, x, k1);
    byte_io(p, 1'b1, x, k2);
    start();
    byte_io({a, 1'b1}, 1'b1, x, k3);
    byte_io(8'hFF, 1'b0, d, k4);
    byte_io(8'hFF, 1'b1, d2, k4);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic await_release(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      tick(1);
      ok = (alert_wire === 1'b1);
    end
    tick(4);
  endtask
endmodule // hlar_host_model
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import hlar_pkg::*;
  // ****************************************
  // bench signals and design
  // ****************************************
  // short power-up, yet long enough that reset still shows when the fire write ends
  localparam int PU = 200;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic hw_reset_n_pin = 1'b1;
  logic scan_tick = 1'b0;
  logic core_scanning = 1'b0;
  logic params_reload_done = 1'b0;
  logic nvm_valid = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [6:0] nvm_slave_addr = 7'h00;
  logic scl, host_sda, sda_out, sda_oe, host_alert_n_out, host_alert_n_oe, sda_wire, alert_wire;
  logic params_reload_req, params_src_nvm, gpio_use_shadow, core_reset_n, reg_wr_stb, reg_rd_stb;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic [15:0] wr_last = 16'h0000;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int wr_cnt = 0;
  // both lines pulled up; either party pulls the data line low, only the design pulls the alert line low
  assign sda_wire = !host_sda && !(sda_oe && !sda_out);
  assign alert_wire = !(host_alert_n_oe && !host_alert_n_out);
  assign reg_rd_data = reg_addr ^ 8'hA5;
  hlar_top #(.POWERUP_CYCLES(PU)) i_dut (
    .clk_sys, .reset_n, .hw_reset_n_pin, .scl_in(scl), .sda_in(sda_wire), .sda_out, .sda_oe,
    .host_alert_n_in(alert_wire), .host_alert_n_out, .host_alert_n_oe, .key_event(ev[0]),
    .mode_entered(ev[1]), .comp_done(ev[2]), .shadow_write_done(ev[3]), .burn_done(ev[4]), .scan_tick,
    .core_scanning, .params_reload_done, .nvm_valid, .nvm_slave_addr, .params_reload_req, .params_src_nvm,
    .gpio_use_shadow, .core_reset_n, .reg_addr, .reg_wr_data, .reg_wr_stb, .reg_rd_stb, .reg_rd_data
  );
  hlar_host_model i_host (.clk_sys, .sda_wire, .alert_wire, .scl, .sda_drive(host_sda));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // core side: reload answered one cycle after the request, writes logged
  always @(posedge clk_sys) begin
    cyc++;
    params_reload_done <= params_reload_req;
    if (reg_wr_stb === 1'b1) begin
      wr_cnt++;
      wr_last <= {reg_addr, reg_wr_data};
    end
    if (cyc == 80000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic sw(input logic [7:0] v);
    logic ok;
    i_host.wr(HLAR_DEF_SLAVE_ADDR, HLAR_SOFT_RESET_OFFS, v, ok);
  endtask
  task automatic wait_up();
    logic ok;
    chk({14'h0000, host_alert_n_oe, gpio_use_shadow}, 16'h0002);
    i_host.await_release(ok);
    chk({13'h0000, ok, gpio_use_shadow, params_src_nvm}, {13'h0000, 2'b11, nvm_valid});
  endtask
  task automatic power_reset();
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    wait_up();
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_events();
    logic [7:0] d, d2;
    logic ok;
    core_scanning = 1'b1;
    for (int i = 0; i < 5; i++) begin
      ev[i] = 1'b1;
      tick(1);
      ev[i] = 1'b0;
      scan_tick = 1'b1;
      chk({15'h0000, host_alert_n_oe}, 16'h0000);
      tick(1);
      scan_tick = 1'b0;
      tick(2);
      chk({15'h0000, host_alert_n_oe}, 16'h0001);
      i_host.rd(HLAR_DEF_SLAVE_ADDR, i[7:0] + 8'h10, d, d2, ok);
      chk({7'h00, ok, d}, {8'h01, (i[7:0] + 8'h10) ^ 8'hA5});
      chk({8'h00, d2}, {8'h00, (i[7:0] + 8'h11) ^ 8'hA5});
      tick(2);
      chk({15'h0000, host_alert_n_oe}, 16'h0000);
    end
    core_scanning = 1'b0;
    ev[0] = 1'b1;
    tick(1);
    ev[0] = 1'b0;
    tick(30);
    chk({15'h0000, host_alert_n_oe}, 16'h0001);
    i_host.rd(HLAR_DEF_SLAVE_ADDR, 8'h20, d, d2, ok);
    tick(2);
    chk({15'h0000, host_alert_n_oe}, 16'h0000);
  endtask
  task automatic t_soft();
    logic ok;
    int n;
    n = wr_cnt;
    sw(HLAR_SRST_KEY_FIRE);
    sw(HLAR_SRST_KEY_ARM);
    sw(8'h55);
    sw(HLAR_SRST_KEY_FIRE);
    tick(8);
    chk({14'h0000, host_alert_n_oe, gpio_use_shadow}, 16'h0001);
    chk(wr_cnt[15:0], n[15:0]);
    i_host.wr(HLAR_DEF_SLAVE_ADDR, 8'h30, 8'h77, ok);
    chk(wr_last, 16'h3077);
    sw(HLAR_SRST_KEY_ARM);
    sw(HLAR_SRST_KEY_FIRE);
    wait_up();
  endtask
  task automatic t_pin();
    hw_reset_n_pin = 1'b0;
    tick(10);
    chk({14'h0000, host_alert_n_oe, core_reset_n}, 16'h0002);
    tick(300);
    chk({15'h0000, gpio_use_shadow}, 16'h0000);
    hw_reset_n_pin = 1'b1;
    wait_up();
  endtask
  task automatic t_addr();
    logic ok;
    nvm_valid = 1'b1;
    nvm_slave_addr = 7'h3A;
    power_reset();
    i_host.wr(HLAR_DEF_SLAVE_ADDR, 8'h40, 8'h11, ok);
    chk({15'h0000, ok}, 16'h0000);
    i_host.q = 62;
    i_host.wr(7'h3A, 8'h41, 8'h22, ok);
    i_host.q = 16;
    chk({15'h0000, ok}, 16'h0001);
    chk(wr_last, 16'h4122);
  endtask
  initial begin
    power_reset();
    t_events();
    t_soft();
    t_pin();
    t_addr();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
